/* design/bcc_addr.sv */
// forms the 12-bit data address of a file-register access
// assumes bank and idx_base come from the same clock domain
`timescale 1ns/1ps
`include "bcc_map.svh"
module bcc_addr (
  input  wire logic [7:0]  field,
  input  wire logic        acc,
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank,
  input  wire logic [11:0] idx_base,
  output logic      [11:0] addr
);
  always_comb begin
    if (acc) begin
      addr = {bank, field};
    end else if (ext_en && field <= `BCC_IDX_LIMIT) begin
      addr = idx_base + {4'h0, field};
    end else if (field < `BCC_ACCESS_SPLIT) begin
      addr = {4'h0, field};
    end else begin
      addr = {`BCC_SFR_BANK, field};
    end
  end
endmodule // bcc_addr

/* design/bcc_core.sv */
// executes the branch, call, clear, watchdog, complement and compare group
// assumes an apb master on pclk; software loads words and data then starts execution
//
// Behaviour
// - branch on zero adds 2n plus 2
// - call uses two words, literal split 8/12
// - call loads 20-bit literal, two cycles
// - call pushes pc plus 4, fast shadows
// - clear writes zero, sets zero flag only
// - bank bit zero selects access bank
// - bank bit one uses bank select register
// - extended mode low fields are indexed
// - watchdog clear zeroes counter and postscaler
// - watchdog clear sets timeout and powerdown
// - complement inverts, destination bit, flags n z
// - compare subtracts unsigned, skips, no flags
// - compare skip costs two or three cycles
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "bcc_map.svh"
module bcc_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [1:0]  phase,
  output logic             busy
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_NOP} bcc_state_t;
  bcc_state_t      state;
  logic [1:0]      nop_left;
  logic [31:0]     instr;
  logic            ext_en;
  logic            next_two_word;
  logic [7:0]      wreg;
  logic [7:0]      status;
  logic [3:0]      bank;
  logic [20:0]     pc;
  logic [20:0]     stack_top;
  logic [7:0]      working_shadow;
  logic [7:0]      status_shadow;
  logic [3:0]      bank_shadow;
  logic [15:0]     watchdog_counter;
  logic [7:0]      watchdog_post;
  logic [11:0]     data_addr_sel;
  logic [7:0]      data_mem [0:4095];
  logic [11:0]     idx_base;
  bcc_pkg::bcc_dec_t dec;
  logic [11:0]     eff_addr;
  logic [7:0]      fval;
  logic [7:0]      fcomp;
  logic            do_skip;
  logic            taken;
  logic            wr_go;
  logic            apb_wr;
  logic [20:0]     next_pc;

  assign idx_base = `BCC_IDX_BASE_RESET;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign busy   = (state != S_IDLE);
  assign wr_go  = apb_wr && paddr == `BCC_OFS_CTRL && pwdata[`BCC_CTRL_GO] && !busy;

  bcc_decode u_dec (
    .word (instr[15:0]),
    .dec  (dec)
  );

  bcc_addr u_addr (
    .field    (dec.field),
    .acc      (dec.acc),
    .ext_en   (ext_en),
    .bank     (bank),
    .idx_base (idx_base),
    .addr     (eff_addr)
  );

  // ------------------------------------------------------------
  // datapath terms
  // ------------------------------------------------------------
  assign fval    = data_mem[eff_addr];
  assign fcomp   = ~fval;
  always_comb begin
    do_skip = 1'b0;
    taken   = 1'b0;
    unique case (dec.op)
      bcc_pkg::BCC_OP_COMPARE_EQ:  do_skip = (fval == wreg);
      bcc_pkg::BCC_OP_COMPARE_GT:  do_skip = (fval > wreg);
      bcc_pkg::BCC_OP_BRANCH_ZERO: taken   = status[`BCC_ST_Z];
      bcc_pkg::BCC_OP_CALL:        taken   = 1'b1;
      default:                     taken   = 1'b0;
    endcase
  end

  always_comb begin
    next_pc = pc + `BCC_PC_STEP;
    if (dec.op == bcc_pkg::BCC_OP_BRANCH_ZERO && taken) begin
      next_pc = pc + `BCC_PC_STEP + {{12{dec.lit[7]}}, dec.lit, 1'b0};
    end else if (dec.op == bcc_pkg::BCC_OP_CALL) begin
      next_pc = {instr[27:16], dec.lit, 1'b0};
    end else if (do_skip) begin
      next_pc = next_two_word ? pc + `BCC_CALL_RET + `BCC_PC_STEP : pc + `BCC_CALL_RET;
    end
  end

  // ------------------------------------------------------------
  // instruction sequencer: each cycle is four phases
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= S_IDLE;
      phase    <= 2'h0;
      nop_left <= 2'h0;
    end else begin
      unique case (state)
        S_IDLE: begin
          phase <= 2'h0;
          if (wr_go) begin
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          phase <= phase + 2'h1;
          if (phase == 2'h3) begin
            if (taken) begin
              state    <= S_NOP;
              nop_left <= 2'h1;
            end else if (do_skip) begin
              state    <= S_NOP;
              nop_left <= next_two_word ? 2'h2 : 2'h1;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_NOP: begin
          phase <= phase + 2'h1;
          if (phase == 2'h3) begin
            nop_left <= nop_left - 2'h1;
            if (nop_left == 2'h1) begin
              state <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // write phase strobe for the executing instruction
  logic commit;
  assign commit = (state == S_EXEC) && (phase == 2'h3);

  // ------------------------------------------------------------
  // program counter, stack and shadows
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc             <= 21'h0;
      stack_top      <= 21'h0;
      working_shadow <= 8'h00;
      status_shadow  <= 8'h00;
      bank_shadow    <= 4'h0;
    end else if (commit) begin
      pc <= next_pc;
      if (dec.op == bcc_pkg::BCC_OP_CALL) begin
        stack_top <= pc + `BCC_CALL_RET;
        if (dec.fast) begin
          working_shadow <= wreg;
          status_shadow  <= status;
          bank_shadow    <= bank;
        end
      end
    end else if (apb_wr && paddr == `BCC_OFS_PC && !busy) begin
      pc <= pwdata[20:0];
    end
  end

  // ------------------------------------------------------------
  // working register, status and bank
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg   <= 8'h00;
      status <= 8'h00;
      bank   <= 4'h0;
    end else if (commit) begin
      unique case (dec.op)
        bcc_pkg::BCC_OP_CLEAR_FILE: status[`BCC_ST_Z] <= 1'b1;
        bcc_pkg::BCC_OP_WATCHDOG_CLEAR: begin
          status[`BCC_ST_TIMEOUT]   <= 1'b1;
          status[`BCC_ST_POWERDOWN] <= 1'b1;
        end
        bcc_pkg::BCC_OP_COMPLEMENT: begin
          if (!dec.dst) begin
            wreg <= fcomp;
          end
          status[`BCC_ST_N] <= fcomp[7];
          status[`BCC_ST_Z] <= (fcomp == 8'h00);
        end
        default: status <= status;
      endcase
    end else if (apb_wr && !busy) begin
      if (paddr == `BCC_OFS_WREG) wreg <= pwdata[7:0];
      if (paddr == `BCC_OFS_STATUS) status <= pwdata[7:0];
      if (paddr == `BCC_OFS_BANK) bank <= pwdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // data memory
  // ------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (commit && dec.op == bcc_pkg::BCC_OP_CLEAR_FILE) begin
      data_mem[eff_addr] <= 8'h00;
    end else if (commit && dec.op == bcc_pkg::BCC_OP_COMPLEMENT && dec.dst) begin
      data_mem[eff_addr] <= fcomp;
    end else if (apb_wr && !busy && paddr == `BCC_OFS_DATA_VAL) begin
      data_mem[data_addr_sel] <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter <= 16'h0000;
      watchdog_post    <= 8'h00;
    end else if (commit && dec.op == bcc_pkg::BCC_OP_WATCHDOG_CLEAR) begin
      watchdog_counter <= 16'h0000;
      watchdog_post    <= 8'h00;
    end else begin
      watchdog_counter <= watchdog_counter + 16'h0001;
      if (watchdog_counter == 16'hffff) begin
        watchdog_post <= watchdog_post + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr         <= 32'h0;
      ext_en        <= 1'b0;
      next_two_word <= 1'b0;
      data_addr_sel <= 12'h000;
    end else if (apb_wr && !busy) begin
      if (paddr == `BCC_OFS_INSTR) instr <= pwdata;
      if (paddr == `BCC_OFS_DATA_ADDR) data_addr_sel <= pwdata[11:0];
      if (paddr == `BCC_OFS_CTRL) begin
        ext_en        <= pwdata[`BCC_CTRL_EXT];
        next_two_word <= pwdata[`BCC_CTRL_NEXT2W];
      end
    end
  end

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    unique case (paddr)
      `BCC_OFS_CTRL:      rd_mux = {29'h0, next_two_word, ext_en, 1'b0};
      `BCC_OFS_STATUS:    rd_mux = {24'h0, busy, status[6:0]};
      `BCC_OFS_WREG:      rd_mux = {24'h0, wreg};
      `BCC_OFS_BANK:      rd_mux = {28'h0, bank};
      `BCC_OFS_PC:        rd_mux = {11'h0, pc};
      `BCC_OFS_INSTR:     rd_mux = instr;
      `BCC_OFS_DATA_ADDR: rd_mux = {20'h0, data_addr_sel};
      `BCC_OFS_DATA_VAL:  rd_mux = {24'h0, data_mem[data_addr_sel]};
      `BCC_OFS_SHADOW:    rd_mux = {12'h0, bank_shadow, status_shadow, working_shadow};
      `BCC_OFS_STACK:     rd_mux = {11'h0, stack_top};
      `BCC_OFS_WATCHDOG:  rd_mux = {8'h0, watchdog_post, watchdog_counter};
      default:            rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pslverr = psel && penable && !rd_hit;
endmodule // bcc_core

/* design/bcc_decode.sv */
// decodes one instruction word into its kind and fields
// assumes a 16-bit program word from the same clock domain
`timescale 1ns/1ps
`include "bcc_map.svh"
module bcc_decode (
  input  wire logic [15:0]      word,
  output bcc_pkg::bcc_dec_t     dec
);
  always_comb begin
    dec       = '0;
    dec.op    = bcc_pkg::BCC_OP_NONE;
    dec.acc   = word[8];
    dec.dst   = word[9];
    dec.fast  = word[8];
    dec.field = word[7:0];
    dec.lit   = word[7:0];
    if (word[15:8] == `BCC_OPC_BRANCH_ZERO) begin
      dec.op = bcc_pkg::BCC_OP_BRANCH_ZERO;
    end else if (word[15:9] == `BCC_OPC_CALL) begin
      dec.op = bcc_pkg::BCC_OP_CALL;
    end else if (word == `BCC_OPC_WATCHDOG_CLEAR) begin
      dec.op = bcc_pkg::BCC_OP_WATCHDOG_CLEAR;
    end else if (word[15:9] == `BCC_OPC_CLEAR_FILE) begin
      dec.op = bcc_pkg::BCC_OP_CLEAR_FILE;
    end else if (word[15:10] == `BCC_OPC_COMPLEMENT) begin
      dec.op = bcc_pkg::BCC_OP_COMPLEMENT;
    end else if (word[15:9] == `BCC_OPC_COMPARE_EQ) begin
      dec.op = bcc_pkg::BCC_OP_COMPARE_EQ;
    end else if (word[15:9] == `BCC_OPC_COMPARE_GT) begin
      dec.op = bcc_pkg::BCC_OP_COMPARE_GT;
    end
  end
endmodule // bcc_decode

/* design/bcc_map.svh */
// register offsets, field positions, reset values and timing counts for the core slice
// assumes inclusion by bare name from the package and the design modules
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// ------------------------------------------------------------
// apb register offsets (byte addresses)
// ------------------------------------------------------------
`define BCC_OFS_CTRL      12'h000
`define BCC_OFS_STATUS    12'h004
`define BCC_OFS_WREG      12'h008
`define BCC_OFS_BANK      12'h00c
`define BCC_OFS_PC        12'h010
`define BCC_OFS_INSTR     12'h014
`define BCC_OFS_DATA_ADDR 12'h018
`define BCC_OFS_DATA_VAL  12'h01c
`define BCC_OFS_SHADOW    12'h020
`define BCC_OFS_STACK     12'h024
`define BCC_OFS_WATCHDOG  12'h028

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define BCC_CTRL_GO       0
`define BCC_CTRL_EXT      1
`define BCC_CTRL_NEXT2W   2

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define BCC_ST_C          0
`define BCC_ST_DC         1
`define BCC_ST_Z          2
`define BCC_ST_OV         3
`define BCC_ST_N          4
`define BCC_ST_POWERDOWN  5
`define BCC_ST_TIMEOUT    6
`define BCC_ST_BUSY       7

// ------------------------------------------------------------
// opcodes and address limits
// ------------------------------------------------------------
`define BCC_OPC_BRANCH_ZERO    8'he0
`define BCC_OPC_CALL           7'h76
`define BCC_OPC_CALL2          4'hf
`define BCC_OPC_WATCHDOG_CLEAR 16'h0004
`define BCC_OPC_CLEAR_FILE     7'h35
`define BCC_OPC_COMPLEMENT     6'h07
`define BCC_OPC_COMPARE_EQ     7'h31
`define BCC_OPC_COMPARE_GT     7'h32
`define BCC_IDX_LIMIT          8'h5f
`define BCC_ACCESS_SPLIT       8'h60
`define BCC_SFR_BANK           4'hf
`define BCC_IDX_BASE_RESET     12'h000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define BCC_PHASES        4
`define BCC_PC_STEP       21'h000002
`define BCC_CALL_RET      21'h000004

`endif

/* design/bcc_pkg.sv */
// types shared by the core slice modules
// assumes bcc_map.svh sits in the include path
`include "bcc_map.svh"
package bcc_pkg;
  // ------------------------------------------------------------
  // instruction kinds
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    BCC_OP_NONE,
    BCC_OP_BRANCH_ZERO,
    BCC_OP_CALL,
    BCC_OP_CLEAR_FILE,
    BCC_OP_WATCHDOG_CLEAR,
    BCC_OP_COMPLEMENT,
    BCC_OP_COMPARE_EQ,
    BCC_OP_COMPARE_GT
  } bcc_op_t;

  typedef struct packed {
    bcc_op_t    op;
    logic       acc;
    logic       dst;
    logic       fast;
    logic [7:0] field;
    logic [7:0] lit;
  } bcc_dec_t;
endpackage

/* tb/bcc_apb_master.sv */
// apb master model standing on the software side of the core slice
// assumes xfer is called right after a rising edge of pclk
`timescale 1ns/1ps
module bcc_apb_master (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer: idle edge, setup, access held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // bcc_apb_master

/* tb/bcc_core_sva.sv */
// checker for the core slice apb ports and instruction cycle timing
// assumes it is bound onto bcc_core and sees only its ports
`timescale 1ns/1ps
module bcc_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  phase,
  input wire logic        busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // length of the current busy run
  // ------------------------------------------------------------
  logic [4:0] run_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      run_len <= 5'h00;
    else if (busy)
      run_len <= run_len + 5'h01;
    else
      run_len <= 5'h00;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_start;
    $rose(busy) |-> phase == 2'h0;
  endproperty
  a_start: assert property (p_start) else $error("phase not zero at start");
  property p_step;
    busy && $past(busy) |-> phase == $past(phase) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("phase did not step");
  property p_min;
    $rose(busy) |-> busy [*4];
  endproperty
  a_min: assert property (p_min) else $error("cycle shorter than four phases");
  property p_len;
    $fell(busy) |-> run_len == 5'h04 || run_len == 5'h08 || run_len == 5'h0c;
  endproperty
  a_len: assert property (p_len) else $error("busy length not 4, 8 or 12");
  property p_end;
    $fell(busy) |-> $past(phase) == 2'h3;
  endproperty
  a_end: assert property (p_end) else $error("busy ended off last phase");
  property p_cause;
    $rose(busy) |-> $past(psel && penable && pwrite && paddr == 12'h000 && pwdata[0]);
  endproperty
  a_cause: assert property (p_cause) else $error("busy without start write");
  property p_bound;
    $rose(busy) |-> ##[4:12] !busy;
  endproperty
  a_bound: assert property (p_bound) else $error("busy too long");
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    psel && penable && paddr > 12'h028 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error on unmapped address");
  property p_zero;
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
endmodule // bcc_core_sva

bind bcc_core bcc_core_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .phase(phase), .busy(busy));

/* tb/test_cpu_branch_call_clear_compare_ops.sv */
// self-checking bench for the branch, call, clear and compare core slice
// assumes the package, map header, apb master model and checker are compiled first
`timescale 1ns/1ps
module test_cpu_branch_call_clear_compare_ops;
  typedef struct packed {
    logic [11:0] addr;
    logic        err;
    logic [31:0] msk;
    logic [31:0] exp;
  } bcc_note_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  phase;
  logic        busy;
  int          err_count = 0;
  int          n_checks = 0;
  bcc_note_t   q[$];
  bcc_note_t   nt;
  logic [15:0] rnd = 16'heda0;
  logic [7:0]  n8, w8, f, f8, v;
  logic        z, a, x, d, op, n2, sk;
  logic [1:0]  rel;
  logic [11:0] ad, ot;
  logic [31:0] sh;
  logic [33:0] ctab [4] = '{{1'b1, 8'h42, 1'b0, 12'h342, 12'h042}, {1'b0, 8'h42, 1'b0, 12'h042, 12'h342},
                           {1'b0, 8'h80, 1'b0, 12'hf80, 12'h380}, {1'b0, 8'h20, 1'b1, 12'h020, 12'h320}};

  always #10 pclk = ~pclk;

  bcc_apb_master m (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  bcc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase(phase), .busy(busy));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_of_test;
    if (q.size() != 0)
      err_count++;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_cyc(input int e, input int g);
    n_checks++;
    if (g != e) begin
      err_count++;
      $display("mismatch busy cycles expected %0d seen %0d", e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] ba, input logic [31:0] bd);
    logic to;
    m.xfer(w, ba, bd, to);
    if (to) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] wa, input logic [31:0] wd);
    bus(1'b1, wa, wd);
  endtask
  task automatic rd(input logic [11:0] ra, input logic [31:0] e, input logic [31:0] k, input logic er = 1'b0);
    q.push_back('{ra, er, k, e});
    bus(1'b0, ra, 32'h0);
  endtask
  task automatic poke(input logic [11:0] pa, input logic [7:0] dv);
    wr(12'h018, {20'h0, pa});
    wr(12'h01c, {24'h0, dv});
  endtask
  task automatic peek(input logic [11:0] pa, input logic [7:0] e);
    wr(12'h018, {20'h0, pa});
    rd(12'h01c, {24'h0, e}, 32'hff);
  endtask
  task automatic run(input logic [31:0] ins, input logic [2:0] ctl, input int ec);
    int n;
    wr(12'h014, ins);
    wr(12'h000, {29'h0, ctl | 3'h1});
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      if (busy === 1'b1)
        n++;
    end
    cmp_cyc(ec, n);
  endtask
  // ------------------------------------------------------------
  // read monitor
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (presetn && psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      cmp_data($sformatf("read %h", nt.addr), nt.exp & nt.msk, prdata & nt.msk);
      cmp_data("slverr", {31'h0, nt.err}, {31'h0, pslverr});
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h02c, 32'h0, 32'hffffffff, 1'b1);
    for (int i = 0; i < 4; i++) begin
      n8 = i[0] ? 8'h7f : 8'h80;
      z = i[1];
      wr(12'h010, 32'h100);
      wr(12'h004, {29'h0, z, 2'h0});
      run({16'h0, 8'he0, n8}, 3'h0, z ? 8 : 4);
      rd(12'h010, z ? 32'h102 + {{23{n8[7]}}, n8, 1'b0} : 32'h102, 32'h1fffff);
      rd(12'h004, {29'h0, z, 2'h0}, 32'h7f);
    end
    for (int s = 1; s >= 0; s--) begin
      w8 = rnd[7:0];
      rnd = lfsr(rnd);
      wr(12'h008, {24'h0, w8});
      wr(12'h00c, 32'h5);
      wr(12'h004, 32'h19);
      wr(12'h010, 32'h200);
      run({4'hf, 12'habc, 7'h76, s[0], 8'hde}, 3'h0, 8);
      rd(12'h010, 32'h1579bc, 32'h1fffff);
      rd(12'h024, 32'h204, 32'h1fffff);
      if (s == 1)
        sh = {12'h0, 4'h5, 8'h19, w8};
      rd(12'h020, sh, 32'h000f7fff);
    end
    for (int i = 0; i < 4; i++) begin
      {a, f, x, ad, ot} = ctab[i];
      wr(12'h00c, 32'h3);
      poke(ad, 8'h5a);
      poke(ot, 8'ha5);
      wr(12'h004, 32'h1b);
      run({16'h0, 7'h35, a, f}, {1'b0, x, 1'b0}, 4);
      peek(ad, 8'h00);
      peek(ot, 8'ha5);
      rd(12'h004, 32'h1f, 32'h7f);
    end
    for (int i = 0; i < 4; i++) begin
      v = i[1] ? 8'hff : rnd[7:0];
      rnd = lfsr(rnd);
      d = i[0];
      poke(12'h313, v);
      wr(12'h008, 32'h0);
      wr(12'h004, 32'h0);
      run({16'h0, 6'h07, d, 1'b1, 8'h13}, 3'h0, 4);
      peek(12'h313, d ? ~v : v);
      rd(12'h008, {24'h0, d ? 8'h00 : ~v}, 32'hff);
      rd(12'h004, {27'h0, ~v[7], 1'b0, ~v == 8'h0, 2'h0}, 32'h7f);
    end
    for (int i = 0; i < 8; i++) begin
      op = i[0];
      rel = i[2:1];
      n2 = (rel == 2'h3);
      f8 = (rel == 2'h0) ? 8'h80 : (rel == 2'h2) ? 8'h7f : 8'h81;
      sk = op ? (rel == 2'h1 || rel == 2'h3) : (rel == 2'h0);
      poke(12'h355, f8);
      wr(12'h008, 32'h80);
      wr(12'h004, 32'h15);
      wr(12'h010, 32'h400);
      run({16'h0, op ? 7'h32 : 7'h31, 1'b1, 8'h55}, {n2, 2'h1}, sk ? (n2 ? 12 : 8) : 4);
      rd(12'h010, sk ? (n2 ? 32'h406 : 32'h404) : 32'h402, 32'h1fffff);
      rd(12'h004, 32'h15, 32'h7f);
      peek(12'h355, f8);
    end
    wr(12'h004, 32'h0);
    repeat (300) @(posedge pclk);
    run(32'h0004, 3'h0, 4);
    rd(12'h028, 32'h0, 32'h00ffff00);
    rd(12'h004, 32'h60, 32'h7f);
    @(posedge pclk);
    end_of_test();
  end
endmodule // test_cpu_branch_call_clear_compare_ops
